// ==== acstd_decode.sv ====
// Combinational decoder from a ten-bit instruction word to an operation.
// Assumes the word and its valid come from the fetch path on the same clock.
`timescale 1ns/1ps
`include "acstd_map.svh"
module acstd_decode
	import acstd_pkg::*;
#(
	parameter logic [9:0] OPC_WAKE0 = `ACSTD_OPC_WAKE0,
	parameter logic [9:0] OPC_WAKE1 = `ACSTD_OPC_WAKE1
) (
	input wire logic instr_valid,
	input wire logic [`ACSTD_IW-1:0] instr,
	output acstd_op_t op,
	output acstd_nib_t imm
);
	// Immediate field only matters for the memory store
	assign imm = instr[`ACSTD_IMM_MSB:`ACSTD_IMM_LSB];

	// Full-word compare, except the memory store which matches its upper six bits; anything else decodes to none
	always_comb begin
		op = acstd_op_none;
		if (instr_valid) begin
			if (instr == `ACSTD_OPC_WIDE) begin
				op = acstd_op_wide;
			end else if (instr == `ACSTD_OPC_INT1) begin
				op = acstd_op_int1;
			end else if (instr == OPC_WAKE0) begin
				op = acstd_op_wake0;
			end else if (instr == OPC_WAKE1) begin
				op = acstd_op_wake1;
			end else if (instr == `ACSTD_OPC_WAKE2) begin
				op = acstd_op_wake2;
			end else if (instr[`ACSTD_IW-1:`ACSTD_HI_LSB] == `ACSTD_OPC_RAM_HI) begin
				op = acstd_op_ram;
			end else if (instr == `ACSTD_OPC_CLK) begin
				op = acstd_op_clk;
			end else if (instr == `ACSTD_OPC_PU0) begin
				op = acstd_op_pu0;
			end
		end
	end
endmodule : acstd_decode

// ==== acstd_fetch.sv ====
// Fetch path model: hands one instruction word a cycle to the decoder.
// Assumes requests come from the bench just after a rising edge.
`timescale 1ns/1ps
module acstd_fetch
	import acstd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic [9:0] req_word,
	input acstd_nib_t req_acc,
	input acstd_nib_t req_b,
	output logic instr_valid,
	output logic [9:0] instr,
	output acstd_nib_t acc,
	output acstd_nib_t reg_b
);
	// Outside a fetch the lines flip, so a stale word never looks valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_valid <= 1'b0;
			instr <= 10'h000;
			acc <= 4'h0;
			reg_b <= 4'h0;
		end else if (req) begin
			instr_valid <= 1'b1;
			instr <= req_word;
			acc <= req_acc;
			reg_b <= req_b;
		end else begin
			instr_valid <= 1'b0;
			instr <= ~instr;
			acc <= ~acc;
			reg_b <= ~reg_b;
		end
	end
endmodule : acstd_fetch

// ==== acstd_map.svh ====
// Opcodes, register offsets, field positions and reset values for the
// accumulator store decoder. Included by the design modules, the checker and the bench.
`ifndef ACSTD_MAP_SVH
`define ACSTD_MAP_SVH

// Instruction word width
`define ACSTD_IW 10
// Fixed ten-bit opcodes
`define ACSTD_OPC_WIDE 10'h01A
`define ACSTD_OPC_INT1 10'h217
`define ACSTD_OPC_WAKE2 10'h215
`define ACSTD_OPC_CLK 10'h216
`define ACSTD_OPC_PU0 10'h22D
// Wake zero and one opcodes, module parameter defaults
`define ACSTD_OPC_WAKE0 10'h21B
`define ACSTD_OPC_WAKE1 10'h214
// Memory store: upper six bits fixed, low four bits carry j
`define ACSTD_OPC_RAM_HI 6'h2B
`define ACSTD_IMM_LSB 0
`define ACSTD_IMM_MSB 3
`define ACSTD_HI_LSB 4

// APB byte offsets
`define ACSTD_OFF_CTRL 8'h00
`define ACSTD_OFF_STAT 8'h04
`define ACSTD_OFF_WIDE 8'h08
`define ACSTD_OFF_INTWK 8'h0C
`define ACSTD_OFF_CLKPU 8'h10
`define ACSTD_OFF_PTR 8'h14
`define ACSTD_OFF_RADDR 8'h18
`define ACSTD_OFF_RDATA 8'h1C

// Field positions
`define ACSTD_CTRL_EN 0
`define ACSTD_PTR_Y_LSB 4
`define ACSTD_STAT_CNT_LSB 0
`define ACSTD_STAT_CNT_MSB 15

// Reset values
`define ACSTD_RST_NIB 4'h0
`define ACSTD_RST_WIDE 8'h00
`define ACSTD_RST_EN 1'b1
`define ACSTD_RST_CNT 16'h0000
`define ACSTD_ZERO32 32'h0000_0000

`endif

// ==== acstd_pkg.sv ====
// Types shared by the accumulator store decoder modules.
// Assumes acstd_map.svh is on the include path.
package acstd_pkg;
	// Decoded operation of one instruction word
	typedef enum logic [3:0] {
		acstd_op_none,
		acstd_op_wide,
		acstd_op_int1,
		acstd_op_wake0,
		acstd_op_wake1,
		acstd_op_wake2,
		acstd_op_ram,
		acstd_op_clk,
		acstd_op_pu0
	} acstd_op_t;
	// A nibble of the four-bit datapath
	typedef logic [3:0] acstd_nib_t;
endpackage : acstd_pkg

// ==== acstd_ram.sv ====
// Flip-flop data memory of four-bit words, one write port, one read port.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/1ps
`include "acstd_map.svh"
module acstd_ram
	import acstd_pkg::*;
#(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input acstd_nib_t wdata,
	input wire logic [AW-1:0] raddr,
	output acstd_nib_t rdata
);
	// Storage array, cleared at reset so reads are never undefined
	acstd_nib_t mem_r [DEPTH];

	// One flop group per word
	for (genvar i = 0; i < DEPTH; i++) begin : g_word
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mem_r[i] <= `ACSTD_RST_NIB;
			end else if (we && (waddr == AW'(i))) begin
				mem_r[i] <= wdata;
			end
		end
	end

	// Read by index
	assign rdata = mem_r[raddr];
endmodule : acstd_ram

// ==== acstd_top.sv ====
// Execute stage for the accumulator store instructions, with an APB slave
// that exposes the destination registers. Assumes instr, instr_valid, acc
// and reg_b come from core logic on pclk, so they are not synchronised.
// The destinations are plain flops; the interrupt, wakeup, clock and pull-up
// logic that reads them lives elsewhere. The software enable is a debug aid:
// a word offered while it is low is dropped, not retried, so normal code
// must leave it set.
//
// Operation
// - combined opcode loads wide register from B,A
// - copy accumulator into interrupt control one
// - copy accumulator into selected wakeup control register
// - store accumulator at pointer, then X xor j
// - copy accumulator into clock control register
// - copy accumulator into pull-up control zero
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "acstd_map.svh"
module acstd_top
	import acstd_pkg::*;
#(
	parameter logic [9:0] OPC_WAKE0 = `ACSTD_OPC_WAKE0,
	parameter logic [9:0] OPC_WAKE1 = `ACSTD_OPC_WAKE1,
	parameter int RAM_DEPTH = 256,
	parameter int RAM_AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	// Fetch path
	input wire logic instr_valid,
	input wire logic [`ACSTD_IW-1:0] instr,
	input acstd_nib_t acc,
	input acstd_nib_t reg_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Destinations as seen by the rest of the chip
	output logic [7:0] wide_reg,
	output acstd_nib_t int_ctrl_one,
	output acstd_nib_t wake_ctrl_zero,
	output acstd_nib_t wake_ctrl_one,
	output acstd_nib_t wake_ctrl_two,
	output acstd_nib_t clock_ctrl_reg,
	output acstd_nib_t pullup_ctrl_zero,
	output acstd_nib_t reg_x,
	output acstd_nib_t reg_y,
	output logic instr_done,
	output logic carry_write,
	output logic skip_next
);
	acstd_op_t op; // Decoded operation this cycle
	acstd_nib_t imm; // Immediate j of the memory store
	acstd_nib_t ram_rdata; // Memory word at the software read index
	logic exec; // Decoded and allowed to execute
	logic ram_we; // Memory write strobe
	logic [RAM_AW-1:0] ram_ptr; // Data pointer index from Y and X

	logic [7:0] wide_r; // Eight-bit general register
	acstd_nib_t int1_r; // Interrupt control one
	acstd_nib_t wake0_r, wake1_r, wake2_r; // Wakeup controls
	acstd_nib_t clk_r; // Clock control
	acstd_nib_t pu0_r; // Pull-up control zero
	acstd_nib_t x_r, y_r; // Pointer registers
	logic done_r; // Completion pulse
	logic en_r; // Software execute enable
	logic [15:0] cnt_r; // Executed instruction count
	logic [RAM_AW-1:0] raddr_r; // Software memory read index
	logic carry_r; // Carry write request, never raised by this group
	logic skip_r; // Skip request, never raised by this group

	logic [31:0] prdata_r; // Registered read data
	logic pready_r; // Registered ready, one wait state
	logic pslverr_r; // Registered error for unmapped offsets
	logic [31:0] rd_nxt; // Read mux
	logic hit_nxt; // Offset decodes to a register
	logic apb_wr; // Write completes this edge

	// Decoder: full ten-bit compare except the memory store's six-bit prefix,
	// so a word of another group never reaches a destination through a partial match
	acstd_decode #(
		.OPC_WAKE0(OPC_WAKE0),
		.OPC_WAKE1(OPC_WAKE1)
	) u_decode (
		.instr_valid(instr_valid),
		.instr(instr),
		.op(op),
		.imm(imm)
	);

	// Execution is gated by software so a debugger can freeze the registers.
	// Done and the count follow exec, so a frozen word leaves no trace.
	assign exec = en_r && (op != acstd_op_none);
	assign ram_we = en_r && (op == acstd_op_ram);
	// Pointer is truncated to the memory depth; higher pointer bits alias,
	// so a smaller memory wraps instead of writing past its last word
	assign ram_ptr = RAM_AW'({y_r, x_r});

	// Data memory; the store writes at the pointer held before this word's
	// xor step, because the pointer flops only update at the same edge
	acstd_ram #(
		.DEPTH(RAM_DEPTH),
		.AW(RAM_AW)
	) u_ram (
		.pclk(pclk),
		.presetn(presetn),
		.we(ram_we),
		.waddr(ram_ptr),
		.wdata(acc),
		.raddr(raddr_r),
		.rdata(ram_rdata)
	);

	// Wide register takes B high and A low together, in one edge,
	// so no reader ever sees half of an update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wide_r <= `ACSTD_RST_WIDE;
		end else if (en_r && op == acstd_op_wide) begin
			wide_r <= {reg_b, acc};
		end
	end

	// Interrupt control one; the whole nibble is copied, no bit of it is
	// reserved at this level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int1_r <= `ACSTD_RST_NIB;
		end else if (en_r && op == acstd_op_int1) begin
			int1_r <= acc;
		end
	end

	// Wakeup control registers, one per opcode; the first two opcodes are
	// parameters, so a decoder change never needs an edit here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake0_r <= `ACSTD_RST_NIB;
			wake1_r <= `ACSTD_RST_NIB;
			wake2_r <= `ACSTD_RST_NIB;
		end else if (en_r) begin
			case (op)
				acstd_op_wake0: wake0_r <= acc;
				acstd_op_wake1: wake1_r <= acc;
				acstd_op_wake2: wake2_r <= acc;
				default: begin
					// Other operations leave the wakeup controls alone
				end
			endcase
		end
	end

	// Clock control. It selects the operating clock, so a stray write would
	// change the core's speed: only its own opcode may load it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_r <= `ACSTD_RST_NIB;
		end else if (en_r && op == acstd_op_clk) begin
			clk_r <= acc;
		end
	end

	// Pull-up control zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pu0_r <= `ACSTD_RST_NIB;
		end else if (en_r && op == acstd_op_pu0) begin
			pu0_r <= acc;
		end
	end

	// Pointer X: the store uses the old X, the xor result is seen next cycle.
	// An instruction beats a software write in the same cycle, so a program
	// never loses its own pointer step to a debugger poking the register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			x_r <= `ACSTD_RST_NIB;
		end else if (ram_we) begin
			x_r <= x_r ^ imm;
		end else if (apb_wr && paddr == `ACSTD_OFF_PTR) begin
			x_r <= pwdata[3:0]; // Software load when no store competes
		end
	end

	// Pointer Y: only software moves it; no opcode of this group steps it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			y_r <= `ACSTD_RST_NIB;
		end else if (apb_wr && paddr == `ACSTD_OFF_PTR) begin
			y_r <= pwdata[`ACSTD_PTR_Y_LSB+3:`ACSTD_PTR_Y_LSB];
		end
	end

	// Each instruction is one word and finishes in the cycle it is presented,
	// so the done pulse is exec delayed by one flop, high for one cycle per executed word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
		end else begin
			done_r <= exec;
		end
	end

	// Executed word count; it wraps silently, software reads differences
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= `ACSTD_RST_CNT;
		end else if (exec) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// Software execute enable; a change applies to the word after the write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r <= `ACSTD_RST_EN;
		end else if (apb_wr && paddr == `ACSTD_OFF_CTRL) begin
			en_r <= pwdata[`ACSTD_CTRL_EN];
		end
	end

	// Memory read index, for inspection only; it never moves the pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raddr_r <= '0;
		end else if (apb_wr && paddr == `ACSTD_OFF_RADDR) begin
			raddr_r <= pwdata[RAM_AW-1:0];
		end
	end

	// Write completes at the edge where ready is seen in the access phase.
	// Reads have no side effect, so only writes need a strobe.
	assign apb_wr = psel && penable && pready_r && pwrite && hit_nxt;

	// Read mux and address decode; unused bits read as zero.
	// Writes to read-only offsets hit too, and are dropped without an error.
	always_comb begin
		rd_nxt = `ACSTD_ZERO32;
		hit_nxt = 1'b1;
		case (paddr)
			`ACSTD_OFF_CTRL: rd_nxt[`ACSTD_CTRL_EN] = en_r;
			`ACSTD_OFF_STAT: rd_nxt[`ACSTD_STAT_CNT_MSB:`ACSTD_STAT_CNT_LSB] = cnt_r;
			`ACSTD_OFF_WIDE: rd_nxt[7:0] = wide_r;
			`ACSTD_OFF_INTWK: rd_nxt[15:0] = {wake2_r, wake1_r, wake0_r, int1_r};
			`ACSTD_OFF_CLKPU: rd_nxt[7:0] = {pu0_r, clk_r};
			`ACSTD_OFF_PTR: rd_nxt[7:0] = {y_r, x_r};
			`ACSTD_OFF_RADDR: rd_nxt[RAM_AW-1:0] = raddr_r;
			`ACSTD_OFF_RDATA: rd_nxt[3:0] = ram_rdata;
			default: hit_nxt = 1'b0;
		endcase
	end

	// One wait state keeps every bus output on a flop; the cost is one extra
	// cycle per transfer, which a debug port can afford. Read data is taken
	// from the mux a cycle before ready, so a word executed in that cycle
	// shows up on the next read, not this one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= `ACSTD_ZERO32;
			pslverr_r <= 1'b0;
		end else if (psel && penable && !pready_r) begin
			pready_r <= 1'b1;
			prdata_r <= pwrite ? `ACSTD_ZERO32 : rd_nxt;
			pslverr_r <= !hit_nxt;
		end else begin
			pready_r <= 1'b0;
			prdata_r <= `ACSTD_ZERO32;
			pslverr_r <= 1'b0;
		end
	end

	// Carry and skip requests. None of these opcodes touches the carry or
	// skips the next word, so both flops load zero on every edge; keeping
	// them on flops gives the core a registered, glitch-free request line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			carry_r <= 1'b0;
			skip_r <= 1'b0;
		end else begin
			carry_r <= 1'b0;
			skip_r <= 1'b0;
		end
	end

	// Outputs
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign wide_reg = wide_r;
	assign int_ctrl_one = int1_r;
	assign wake_ctrl_zero = wake0_r;
	assign wake_ctrl_one = wake1_r;
	assign wake_ctrl_two = wake2_r;
	assign clock_ctrl_reg = clk_r;
	assign pullup_ctrl_zero = pu0_r;
	assign reg_x = x_r;
	assign reg_y = y_r;
	assign instr_done = done_r;
	assign carry_write = carry_r;
	assign skip_next = skip_r;
endmodule : acstd_top

// ==== acstd_top_asserts.sv ====
// Checker for the accumulator store decoder top.
// Assumes it is bound to acstd_top and sees only that module's ports.
`timescale 1ns/1ps
`include "acstd_map.svh"
module acstd_chk
	import acstd_pkg::*;
#(
	parameter logic [9:0] OPC_WAKE0 = `ACSTD_OPC_WAKE0,
	parameter logic [9:0] OPC_WAKE1 = `ACSTD_OPC_WAKE1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic instr_valid,
	input wire logic [9:0] instr,
	input acstd_nib_t acc,
	input acstd_nib_t reg_b,
	input wire logic psel,
	input wire logic penable,
	input logic pready,
	input logic pslverr,
	input logic [7:0] wide_reg,
	input acstd_nib_t int_ctrl_one,
	input acstd_nib_t wake_ctrl_zero,
	input acstd_nib_t wake_ctrl_one,
	input acstd_nib_t wake_ctrl_two,
	input acstd_nib_t clock_ctrl_reg,
	input acstd_nib_t pullup_ctrl_zero,
	input acstd_nib_t reg_x,
	input logic instr_done,
	input logic carry_write,
	input logic skip_next
);
	// Immediate field of the memory store, kept as a signal for $past
	acstd_nib_t imm_j;
	assign imm_j = instr[3:0];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// A word offered and really executed, judged by the done pulse
	sequence ex(logic [9:0] o);
		instr_valid && instr == o ##1 instr_done;
	endsequence
	a_wide_load: assert property (ex(`ACSTD_OPC_WIDE) |-> wide_reg == {$past(reg_b), $past(acc)})
		else $error("wide register not loaded from b and acc");
	a_int_copy: assert property (ex(`ACSTD_OPC_INT1) |-> int_ctrl_one == $past(acc))
		else $error("int control one not loaded");
	a_wake_zero: assert property (ex(OPC_WAKE0) |-> wake_ctrl_zero == $past(acc))
		else $error("wake control zero not loaded");
	a_wake_one: assert property (ex(OPC_WAKE1) |-> wake_ctrl_one == $past(acc))
		else $error("wake control one not loaded");
	a_wake_two: assert property (ex(`ACSTD_OPC_WAKE2) |-> wake_ctrl_two == $past(acc))
		else $error("wake control two not loaded");
	a_ram_xor: assert property (instr_valid && instr[9:4] == `ACSTD_OPC_RAM_HI ##1 instr_done
		|-> reg_x == ($past(reg_x) ^ $past(imm_j)))
		else $error("pointer x not updated by xor");
	a_clock_copy: assert property (ex(`ACSTD_OPC_CLK) |-> clock_ctrl_reg == $past(acc))
		else $error("clock control not loaded");
	a_pullup_copy: assert property (ex(`ACSTD_OPC_PU0) |-> pullup_ctrl_zero == $past(acc))
		else $error("pull-up zero not loaded");
	a_no_side: assert property (!carry_write && !skip_next)
		else $error("carry or skip touched");
	a_done_cause: assert property (instr_done |-> $past(instr_valid))
		else $error("done without a word");
	a_apb_ready: assert property (psel && penable && !pready |=> pready)
		else $error("apb access not answered");
	// Main scenarios reached
	c_wide: cover property (ex(`ACSTD_OPC_WIDE));
	c_err: cover property (pready && pslverr);
	c_b2b: cover property (instr_done [*2]);
endmodule : acstd_chk

bind acstd_top acstd_chk #(.OPC_WAKE0(OPC_WAKE0), .OPC_WAKE1(OPC_WAKE1)) i_acstd_chk (.*);

// ==== tb_accumulator_store_decoder.sv ====
// Bench for the accumulator store decoder: fetch model plus APB master.
// Assumes acstd_top, acstd_fetch and the checker are compiled first.
`timescale 1ns/1ps
`include "acstd_map.svh"
module tb_accumulator_store_decoder
	import acstd_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, req = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0] req_word = 10'h000;
	acstd_nib_t req_acc = 4'h0, req_b = 4'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic instr_valid, pready, pslverr, instr_done, carry_write, skip_next;
	logic [9:0] instr;
	logic [7:0] wide_reg;
	acstd_nib_t acc, reg_b, int_ctrl_one, wake_ctrl_zero, wake_ctrl_one, wake_ctrl_two;
	acstd_nib_t clock_ctrl_reg, pullup_ctrl_zero, reg_x, reg_y, xs;
	logic [11:0] eq[$];  // Expected {destination, value} per executed word
	logic [32:0] aq[$];  // Expected {error, data} per APB read
	logic [3:0] mem [256];
	logic [7:0] lv [8];
	logic [11:0] e;
	int err_total = 0, total_checks = 0, k;
	// Opcode table, index = destination code
	logic [9:0] ops [7] = '{`ACSTD_OPC_WIDE, `ACSTD_OPC_INT1, `ACSTD_OPC_WAKE0,
		`ACSTD_OPC_WAKE1, `ACSTD_OPC_WAKE2, `ACSTD_OPC_CLK, `ACSTD_OPC_PU0};
	wire logic [63:0] ob = {4'h0, reg_x, 4'h0, pullup_ctrl_zero, 4'h0, clock_ctrl_reg,
		4'h0, wake_ctrl_two, 4'h0, wake_ctrl_one, 4'h0, wake_ctrl_zero, 4'h0, int_ctrl_one, wide_reg};

	acstd_top i_acstd_top (.*);
	acstd_fetch i_acstd_fetch (.*);

	always #2.5 pclk = ~pclk;

	task cmp_ins(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: dest %h want %h", $time, got, exp);
		end
	endtask : cmp_ins

	task cmp_apb(input logic [32:0] got, input logic [32:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: apb %h want %h", $time, got, exp);
		end
	endtask : cmp_apb

	// Destination code 15 marks a word that must be ignored
	task ins(input logic [9:0] w, input logic [3:0] kd, input acstd_nib_t a, input acstd_nib_t b);
		logic [7:0] v;
		v = (kd == 4'h0) ? {b, a} : {4'h0, a};
		if (kd == 4'h7) begin
			mem[{4'h1, xs}] = a;
			xs = xs ^ w[3:0];
			v = {4'h0, xs};
		end
		if (kd != 4'hf) begin
			lv[kd[2:0]] = v;
			eq.push_back({kd, v});
		end
		@(posedge pclk);
		req <= 1'b1;
		req_word <= w;
		req_acc <= a;
		req_b <= b;
	endtask : ins

	task idle;
		@(posedge pclk);
		req <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : idle

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
		int n;
		if (!w) aq.push_back(x);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			cmp_apb(33'h0_0000_0000, 33'h1_0000_0000);
			print_verdict;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// Every done pulse takes the oldest note; an unplanned pulse finds none
	always @(posedge pclk) begin
		if (instr_done === 1'b1) begin
			e = eq.size() ? eq.pop_front() : 12'hfff;
			cmp_ins(ob[e[11:8] * 8 +: 8], e[7:0]);
		end
		if (psel && penable && pready === 1'b1 && !pwrite)
			cmp_apb({pslverr, prdata}, aq.pop_front());
	end

	initial begin
		repeat (20000) @(posedge pclk);
		$display("unexpected at %0t: timeout", $time);
		err_total++;
		print_verdict;
	end

	initial begin
		void'($urandom(32'h8a1e));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `ACSTD_OFF_CTRL, 32'h0000_0000, 33'h0_0000_0001);
		apb(1'b0, `ACSTD_OFF_WIDE, 32'h0000_0000, 33'h0_0000_0000);
		$display("test reset done");
		// Every opcode except the memory store twice, back to back, random data
		for (k = 0; k < 14; k++) ins(ops[k % 7], 4'(k % 7), 4'($urandom()), 4'($urandom()));
		idle;
		$display("test opcodes done");
		// Pointer X=2 Y=1, then every immediate back to back
		apb(1'b1, `ACSTD_OFF_PTR, 32'h0000_0012, 33'h0_0000_0000);
		xs = 4'h2;
		for (k = 0; k < 16; k++) ins({`ACSTD_OPC_RAM_HI, 4'(k)}, 4'h7, 4'($urandom()), 4'($urandom()));
		idle;
		apb(1'b1, `ACSTD_OFF_RADDR, 32'h0000_0012, 33'h0_0000_0000);
		apb(1'b0, `ACSTD_OFF_RDATA, 32'h0000_0000, {29'h0, mem[8'h12]});
		apb(1'b0, `ACSTD_OFF_PTR, 32'h0000_0000, {25'h0, 4'h1, xs});
		cmp_ins({4'h0, reg_y}, 8'h01);
		$display("test memory done");
		// Disabled decoder and an unknown word are both ignored
		apb(1'b1, `ACSTD_OFF_CTRL, 32'h0000_0000, 33'h0_0000_0000);
		ins(`ACSTD_OPC_INT1, 4'hf, ~lv[1][3:0], 4'h0);
		idle;
		apb(1'b1, `ACSTD_OFF_CTRL, 32'h0000_0001, 33'h0_0000_0000);
		ins(10'h3ff, 4'hf, 4'h5, 4'ha);
		idle;
		apb(1'b0, `ACSTD_OFF_INTWK, 32'h0000_0000,
			{17'h0_0000, lv[4][3:0], lv[3][3:0], lv[2][3:0], lv[1][3:0]});
		apb(1'b0, `ACSTD_OFF_CLKPU, 32'h0000_0000, {25'h0, lv[6][3:0], lv[5][3:0]});
		apb(1'b0, `ACSTD_OFF_WIDE, 32'h0000_0000, {25'h0, lv[0]});
		apb(1'b0, `ACSTD_OFF_STAT, 32'h0000_0000, 33'h0_0000_001e);
		apb(1'b0, 8'h20, 32'h0000_0000, 33'h1_0000_0000);
		cmp_ins({6'h00, carry_write, skip_next}, 8'h00);
		$display("test refusal done");
		repeat (5) @(posedge pclk);
		print_verdict;
	end
endmodule : tb_accumulator_store_decoder
